// ===== sim/asr_host_model.sv
// host model: drives select pins and serial clock, captures serial data
`timescale 1ns/1ns
module asr_host_model
(
    input wire logic mclk,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n,
    output logic convert_start,
    output logic serial_in_select,
    output logic serial_clk
);
    // a released line reads high through the pull-up, never a stale bit
    wire logic sdo_line = serial_out_oe_n ? 1'b1 : serial_out_o;
    initial
    begin
        convert_start = 1'b0;
        serial_in_select = 1'b1;
        serial_clk = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    // levels held through conversion pick busy or no-busy readout
    task automatic pins(input logic cnv, input logic sel);
        @(posedge mclk);
        convert_start <= cnv;
        serial_in_select <= sel;
    endtask : pins
    task automatic rise();
        pins(1'b0, 1'b1);
        idle(4);
        pins(1'b1, 1'b1);
    endtask : rise
    // 80 ns serial clock, low outside frames; bit taken just before each rise
    task automatic read_bits(input int n, output logic [31:0] word);
        word = '0;
        for (int i = 0; i < n; i++)
        begin
            idle(5);
            word = {word[30:0], sdo_line};
            serial_clk <= 1'b1;
            idle(5);
            serial_clk <= 1'b0;
        end
    endtask : read_bits
endmodule : asr_host_model

// ===== sim/asr_readout_test.sv
// testbench: select-mode conversions and readouts of the serial readout block
`timescale 1ns/1ns
module asr_readout_test;
    import asr_pkg::*;
    localparam int CONV_TB = 200;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [RESULT_BITS-1:0] core_result = '0;
    logic convert_start, serial_in_select, serial_clk;
    logic core_start, chain_mode, serial_out_o, serial_out_oe_n;
    logic [31:0] word;
    int failures = 0;
    int comparisons = 0;
    int n;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    asr_readout #(.CONV_CYCLES(CONV_TB)) asr_readout_inst
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .convert_start(convert_start),
        .serial_in_select(serial_in_select),
        .serial_clk(serial_clk),
        .core_result(core_result),
        .core_start(core_start),
        .chain_mode(chain_mode),
        .serial_out_o(serial_out_o),
        .serial_out_oe_n(serial_out_oe_n)
    );
    asr_host_model asr_host_model_inst
    (
        .mclk(mclk),
        .serial_out_o(serial_out_o),
        .serial_out_oe_n(serial_out_oe_n),
        .convert_start(convert_start),
        .serial_in_select(serial_in_select),
        .serial_clk(serial_clk)
    );

    task automatic finish_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_range(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("[ERR] %0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_range
    // bounded wait for a start pulse or for the busy-low flag
    task automatic wait_for(input bit busy, input int lim, output int k);
        for (k = 0; k < lim; k++)
        begin
            @(posedge mclk);
            #1;
            if (busy ? serial_out_oe_n === 1'b0 : core_start === 1'b1)
                break;
        end
        if (k == lim)
        begin
            failures++;
            finish_test();
        end
    endtask : wait_for

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic convert(input logic [17:0] val, input logic cnv, input logic sel);
        @(posedge mclk);
        core_result <= val;
        asr_host_model_inst.rise();
        wait_for(1'b0, 12, n);
        check_val(32'(chain_mode), 32'h0);
        check_val(32'(serial_out_oe_n), 32'h1);
        asr_host_model_inst.pins(cnv, sel);
    endtask : convert
    // no busy flag may appear; then the given pin levels present the MSB (convert-start low or select-line low)
    task automatic present(input logic cnv, input logic sel);
        asr_host_model_inst.idle(CONV_TB + 10);
        #1;
        check_val(32'(serial_out_oe_n), 32'h1);
        asr_host_model_inst.pins(cnv, sel);
        asr_host_model_inst.idle(4);
    endtask : present
    task automatic sc_nobusy(input logic four, input logic [17:0] val);
        convert(val, 1'b1, ~four);
        asr_host_model_inst.idle(30);
        // 3-wire pulses convert-start, 4-wire the select line, mid-conversion
        asr_host_model_inst.pins(four, ~four);
        asr_host_model_inst.pins(1'b1, 1'b1);
        present(four, ~four);
        asr_host_model_inst.read_bits(EDGES_NO_BUSY, word);
        check_val(word, 32'(val));
        asr_host_model_inst.idle(6);
        #1;
        check_val(32'(serial_out_oe_n), 32'h1);
    endtask : sc_nobusy
    task automatic sc_busy(input logic four, input logic [17:0] val);
        convert(val, four, ~four);
        wait_for(1'b1, 300, n);
        check_range(n, CONV_TB - 6, CONV_TB + 4);
        check_val(32'(serial_out_o), 32'h0);
        asr_host_model_inst.read_bits(EDGES_BUSY, word);
        check_val(word, 32'(val));
        asr_host_model_inst.idle(6);
        #1;
        check_val(32'(serial_out_oe_n), 32'h1);
    endtask : sc_busy
    // short read: leftover bits come out on the next read in place of the newer result
    task automatic sc_short;
        convert(18'h3C0F5, 1'b1, 1'b1);
        present(1'b0, 1'b1);
        asr_host_model_inst.read_bits(10, word);
        check_val(word, 32'h003C0);
        convert(18'h15A6E, 1'b1, 1'b1);
        present(1'b0, 1'b1);
        asr_host_model_inst.read_bits(8, word);
        check_val(word, 32'h000F5);
    endtask : sc_short
    task automatic sc_chain;
        asr_host_model_inst.pins(1'b0, 1'b0);
        asr_host_model_inst.idle(5);
        #1;
        check_val({30'h0, serial_out_oe_n, serial_out_o}, 32'h0);
        n = 0;
        asr_host_model_inst.pins(1'b1, 1'b0);
        for (int k = 0; k < 12; k++)
        begin
            @(posedge mclk);
            #1;
            if (core_start === 1'b1)
                n++;
        end
        check_range(n, 0, 0);
        check_val(32'(chain_mode), 32'h1);
    endtask : sc_chain

    // reset for 8 cycles, then every mode in turn
    initial
    begin
        asr_host_model_inst.idle(4);
        #1;
        check_val({29'h0, serial_out_oe_n, core_start, chain_mode}, 32'h4);
        asr_host_model_inst.idle(4);
        arst_n <= 1'b1;
        asr_host_model_inst.idle(4);
        sc_nobusy(1'b0, 18'h2A5C3);
        sc_nobusy(1'b1, 18'h1B7E4);
        sc_busy(1'b0, 18'h0F0F1);
        sc_busy(1'b1, 18'h20001);
        sc_short();
        sc_chain();
        sc_nobusy(1'b0, 18'h3FFFE);
        finish_test();
    end
endmodule : asr_readout_test

// ===== verilog/asr_pin_sync.sv
// module: two-stage pin synchronisers and edge detection
`timescale 1ns/1ns
module asr_pin_sync
    import asr_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic convert_start,
    input wire logic serial_in_select,
    input wire logic serial_clk,
    asr_sync_if.src sync
);
    logic [2:0] meta;
    logic [2:0] stable;
    logic [2:0] prev;

    // ------------------------------------------------------------
    // synchronisers; the meta stage feeds only the stable stage
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // serial clock rests low between frames; a matching reset level avoids a false fall
            meta <= 3'h3;
            stable <= 3'h3;
            prev <= 3'h3;
        end
        else
        begin
            meta <= {serial_clk, serial_in_select, convert_start};
            stable <= meta;
            prev <= stable;
        end
    end

    // edge pulses come from the stable stage only
    assign sync.conv_lvl = stable[0];
    assign sync.sel_lvl = stable[1];
    assign sync.sclk_lvl = stable[2];
    assign sync.conv_rise = stable[0] & ~prev[0];
    assign sync.conv_fall = ~stable[0] & prev[0];
    assign sync.sclk_fall = ~stable[2] & prev[2];
endmodule : asr_pin_sync

// ===== verilog/asr_pkg.sv
// package: constants and types for the select-mode serial readout block
package asr_pkg;
    // result width and conversion timing
    localparam int RESULT_BITS = 18;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_MIN_NS = 1600;
    localparam int CONV_MAX_NS = 1800;
    // conversion length in clocks: lies between min (rounded up) and max (rounded down)
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_CYC = (CONV_MIN_CYC + CONV_MAX_CYC) / 2;
    // falling edges before release: data only, or busy flush bit plus data
    localparam int EDGES_NO_BUSY = 18;
    localparam int EDGES_BUSY = 19;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

    typedef enum logic [3:0]
    {
        ASR_ACQ = 4'b0001,
        ASR_CONV = 4'b0010,
        ASR_BUSYLOW = 4'b0100,
        ASR_READ = 4'b1000
    } asr_state_type;
endpackage : asr_pkg

// ===== verilog/asr_readout.sv
// top: chip-select mode conversion control and serial readout
//Contract
//- select-line high at convert-start rise picks chip-select interface, low picks chained.
//- busy indication enabled if convert-start or select-line low at conversion end.
//- unread bits of older result go out before any bits of the new one; code drops the new result while bits are left.
//- with select-line high, convert-start rise starts conversion and floats serial_out.
//- conversion runs to its end whatever convert-start does later.
//- after conversion, convert-start low presents the MSB in 3-wire no-busy mode.
//- no-busy modes shift on falling edges, float after 18th edge or convert-start rise.
//- busy modes drive serial_out low at conversion end, then acquire.
//- busy modes shift result MSB first on falling edges after busy low.
//- busy modes float after 19th falling edge or convert-start rise.
//- 4-wire: convert-start and select-line both low drive serial_out low; code does so only while drive is low, else serial_out carries out_bit.
//- 4-wire no-busy: select-line low presents MSB on serial_out.
`timescale 1ns/1ns
module asr_readout
    import asr_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic convert_start,
    input wire logic serial_in_select,
    input wire logic serial_clk,
    input wire logic [RESULT_BITS-1:0] core_result,
    output logic core_start,
    output logic chain_mode,
    output logic serial_out_o,
    output logic serial_out_oe_n
);
    // a length outside the window would break the host's conversion-time budget
    if (CONV_CYCLES < CONV_MIN_CYC || CONV_CYCLES > CONV_MAX_CYC)
    begin : g_bad_length
        $error("conversion length outside min/max window");
    end

    asr_sync_if sync ();

    asr_pin_sync asr_pin_sync_inst
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .convert_start(convert_start),
        .serial_in_select(serial_in_select),
        .serial_clk(serial_clk),
        .sync(sync)
    );

    asr_state_type state;
    logic [15:0] conv_cnt;
    logic [RESULT_BITS-1:0] shreg;
    logic [4:0] left;
    logic busy_mode;
    logic flush_busy;
    logic drive;
    logic out_bit;
    logic chain;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire start_ok = sync.conv_rise & sync.sel_lvl;
    wire conv_done = (state == ASR_CONV) && (conv_cnt == 16'(CONV_CYCLES - 1));
    wire busy_now = ~sync.conv_lvl | ~sync.sel_lvl;
    // 4-wire present: convert-start high with select-line low; 3-wire: convert-start falls
    wire present = (state == ASR_ACQ) && !busy_mode && !drive && left != 5'h00 &&
        (sync.conv_fall || (sync.conv_lvl && !sync.sel_lvl));
    wire force_low = ~sync.conv_lvl & ~sync.sel_lvl & ~drive;
    wire shift_ev = drive && sync.sclk_fall;
    wire last_edge = shift_ev && (left == 5'h01) && !flush_busy;

    assign core_start = (state == ASR_CONV) && (conv_cnt == 16'h0000);
    assign chain_mode = chain;
    assign serial_out_o = force_low ? 1'b0 : out_bit;
    assign serial_out_oe_n = ~(drive | force_low);

    // ------------------------------------------------------------
    // mode selection at convert-start rise
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            chain <= 1'b0;
        else if (sync.conv_rise)
            chain <= ~sync.sel_lvl;
    end

    // ------------------------------------------------------------
    // conversion timer; runs to the end ignoring convert-start
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ASR_ACQ;
            conv_cnt <= 16'h0000;
        end
        else
        begin
            unique case (state)
                ASR_ACQ:
                    if (start_ok)
                    begin
                        state <= ASR_CONV;
                        conv_cnt <= 16'h0000;
                    end
                ASR_CONV:
                    if (conv_done)
                        state <= busy_now ? ASR_BUSYLOW : ASR_ACQ;
                    else
                        conv_cnt <= conv_cnt + 16'h0001;
                ASR_BUSYLOW:
                    state <= ASR_ACQ;
                ASR_READ:
                    state <= ASR_ACQ;
                default:
                    state <= ASR_ACQ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // output shifter; a short read leaves bits for the next cycle
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shreg <= RESULT_RESET[RESULT_BITS-1:0];
            left <= 5'h00;
            busy_mode <= 1'b0;
            flush_busy <= 1'b0;
            drive <= 1'b0;
            out_bit <= 1'b1;
        end
        else if (sync.conv_rise)
        begin
            drive <= 1'b0;
            out_bit <= 1'b1;
        end
        else if (conv_done)
        begin
            busy_mode <= busy_now;
            // leftovers of the old result win over the new one
            if (left == 5'h00)
            begin
                shreg <= core_result;
                left <= 5'(RESULT_BITS);
            end
            if (busy_now)
            begin
                drive <= 1'b1;
                out_bit <= 1'b0;
                flush_busy <= 1'b1;
            end
        end
        else if (present)
        begin
            drive <= 1'b1;
            out_bit <= shreg[RESULT_BITS-1];
        end
        else if (shift_ev && flush_busy)
        begin
            flush_busy <= 1'b0;
            out_bit <= shreg[RESULT_BITS-1];
        end
        else if (shift_ev)
        begin
            shreg <= {shreg[RESULT_BITS-2:0], 1'b0};
            left <= left - 5'h01;
            out_bit <= shreg[RESULT_BITS-2];
            if (last_edge)
            begin
                drive <= 1'b0;
                out_bit <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // falls counted independently of the shift counter, so a miscount in left shows up
    logic [4:0] frame_edges;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            frame_edges <= 5'h00;
        else if (!drive || sync.conv_rise)
            frame_edges <= 5'h00;
        else if (sync.sclk_fall)
            frame_edges <= frame_edges + 5'h01;
    end

    a_start_floats: assert property (@(posedge mclk) disable iff (!arst_n)
        sync.conv_rise |=> !drive) else $error("output not released on start");
    a_conv_length: assert property (@(posedge mclk) disable iff (!arst_n)
        core_start |-> ##(CONV_CYCLES - 1) conv_done) else $error("conversion length wrong");
    a_conv_holds: assert property (@(posedge mclk) disable iff (!arst_n)
        (state == ASR_CONV && !conv_done) |=> state == ASR_CONV) else $error("conversion aborted");
    a_busy_low: assert property (@(posedge mclk) disable iff (!arst_n)
        (conv_done && busy_now && !sync.conv_rise) |=> (!serial_out_oe_n && !serial_out_o))
        else $error("busy low missing");
    a_busy_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        conv_done |=> busy_mode == $past(busy_now)) else $error("busy mode wrong");
    a_mode_pick: assert property (@(posedge mclk) disable iff (!arst_n)
        sync.conv_rise |=> chain == !$past(sync.sel_lvl)) else $error("mode choice wrong");
    a_four_low: assert property (@(posedge mclk) disable iff (!arst_n)
        (!sync.conv_lvl && !sync.sel_lvl) |-> (!serial_out_oe_n && (drive || !serial_out_o)))
        else $error("forced low missing");
    a_last_release: assert property (@(posedge mclk) disable iff (!arst_n)
        (last_edge && !sync.conv_rise && !conv_done) |=> !drive) else $error("no release after last edge");
    a_keep_left: assert property (@(posedge mclk) disable iff (!arst_n)
        (conv_done && left != 5'h00) |=> $stable(shreg)) else $error("leftover bits lost");
    a_frame_release: assert property (@(posedge mclk) disable iff (!arst_n)
        drive |-> frame_edges < (busy_mode ? 5'(EDGES_BUSY) : 5'(EDGES_NO_BUSY)))
        else $error("output held past last edge");
endmodule : asr_readout

// ===== verilog/asr_sync_if.sv
// interface: synchronised pin levels and their edge pulses
`timescale 1ns/1ns
interface asr_sync_if;
    logic conv_lvl;
    logic sel_lvl;
    logic sclk_lvl;
    logic conv_rise;
    logic conv_fall;
    logic sclk_fall;
    modport src (output conv_lvl, sel_lvl, sclk_lvl, conv_rise, conv_fall, sclk_fall);
    modport dst (input conv_lvl, sel_lvl, sclk_lvl, conv_rise, conv_fall, sclk_fall);
endinterface : asr_sync_if
